// [tail_exec_regs.svh]
/*
 * opcode values, flag bit positions, reset values, vector addresses and push indices for the tail
 * instruction executor; assumes inclusion by bare name from its design files
 */
`ifndef TAIL_EXEC_REGS_SVH
`define TAIL_EXEC_REGS_SVH

// opcodes
`define OPC_SOFTWARE_TRAP    8'h83
`define OPC_WAIT             8'h8f
`define OPC_FLAGS_TO_CCR     8'h84
`define OPC_FLAGS_TO_ACC     8'h85
`define OPC_ACC_TO_INDEX     8'h97
`define OPC_INDEX_TO_ACC     8'h9f
`define OPC_STACKPTR_TO_PAIR 8'h95
`define OPC_PAIR_TO_STACKPTR 8'h94
`define OPC_TEST_ACC         8'h4d
`define OPC_TEST_INDEX       8'h5d
`define OPC_TEST_MEM_DIR     8'h3d
`define OPC_TEST_MEM_IX1     8'h6d
`define OPC_TEST_MEM_IX      8'h7d

// condition flag bit positions
`define FLAG_V 7
`define FLAG_H 4
`define FLAG_I 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0

// reset values
`define RST_FLAGS    8'h68
`define RST_STACKPTR 16'h00ff
`define RST_ACC      8'h00
`define RST_INDEX    16'h0000
`define RST_PC       16'h0000

// trap vector bytes
`define VEC_TRAP_HIGH 16'hfffc
`define VEC_TRAP_LOW  16'hfffd

// trap pushes, last index of the push sequence
`define PUSH_LAST 3'h4
`define PUSH_PCL  3'h0
`define PUSH_PCH  3'h1
`define PUSH_X    3'h2
`define PUSH_A    3'h3

`endif

// [tail_exec_pkg.sv]
/*
 * types shared by the tail instruction executor; no assumptions
 */
`default_nettype none

package tail_exec_pkg;
   typedef enum logic [3:0] {
      st_idle,
      st_push,
      st_set_mask,
      st_vec_high,
      st_vec_low,
      st_waiting,
      st_second
   } exec_state_t;

   typedef logic [7:0] byte_t;
endpackage

`default_nettype wire

// [sign_zero_test.sv]
/*
 * negative and zero evaluation of a value minus zero;
 * assumes a purely combinational operand from the caller
 */
`timescale 1ns/1ps
`default_nettype none

module sign_zero_test #(
   parameter int WIDTH = 8
)(
   input  wire logic [WIDTH-1:0] value,
   output logic                  negative,
   output logic                  zero
);
   // refused at elaboration: a zero-width value has no sign bit
   if (WIDTH < 1)
   begin
      $error("sign_zero_test needs a positive width");
   end

   // subtracting zero leaves the value, so only its sign and emptiness matter
   assign negative = value[WIDTH-1];
   assign zero     = (value == '0);
endmodule

`default_nettype wire

// [tail_exec.sv]
/*
 * executor for the trap, wait, test and transfer instructions of an 8-bit core;
 * assumes the fetch stage presents one opcode at a time, memory reads answer in
 * the same cycle, and irq_req comes from interrupt logic on ref_clk
 */
// Behaviour
// - the trap opcode bumps the program counter, pushes low pc, high pc, index low, accumulator and flags, sets the mask, loads the vector, all in 9 cycles.
// - the wait opcode clears the interrupt mask, keeps every other flag and takes one cycle before waiting.
// - after wait the core stops its own clocking and resumes only when an interrupt request is seen.
// - the test opcodes compare accumulator, index low or a memory operand against zero, clear overflow, set negative and zero and keep half-carry and mask.
`timescale 1ns/1ps
`default_nettype none
`include "tail_exec_regs.svh"

module tail_exec
   import tail_exec_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        op_valid,
   input  wire logic [7:0]  opcode,
   input  wire logic [7:0]  mem_operand,
   input  wire logic        irq_req,
   input  wire logic [7:0]  mem_rdata,
   output logic             op_ready,
   output logic             op_done,
   output logic             clk_run,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   output logic             mem_we,
   output logic             mem_re,
   output logic [7:0]       acc,
   output logic [15:0]      index_pair,
   output logic [15:0]      stack_ptr,
   output logic [15:0]      prog_counter,
   output logic [7:0]       condition_flags
);
   exec_state_t state;
   logic [2:0]  push_idx;
   logic [7:0]  opcode_held;
   logic [7:0]  test_value;
   logic        test_neg;
   logic        test_zero;
   logic        take;
   logic        is_test;
   logic        is_single;
   logic        is_double;

   ////////////////////////////////////////////////////////////////////////////
   // decode

   assign take     = op_valid && (state == st_idle);
   assign op_ready = (state == st_idle);

   always_comb
   begin
      is_test   = 1'b0;
      is_single = 1'b0;
      is_double = 1'b0;
      case (opcode)
         `OPC_TEST_ACC, `OPC_TEST_INDEX, `OPC_TEST_MEM_DIR,
         `OPC_TEST_MEM_IX1, `OPC_TEST_MEM_IX:
         begin
            is_test   = 1'b1;
            is_single = 1'b1;
         end
         `OPC_FLAGS_TO_ACC, `OPC_ACC_TO_INDEX, `OPC_INDEX_TO_ACC:
         begin
            is_single = 1'b1;
         end
         `OPC_FLAGS_TO_CCR, `OPC_STACKPTR_TO_PAIR, `OPC_PAIR_TO_STACKPTR:
         begin
            is_double = 1'b1;
         end
         default:
         begin
            // unknown opcodes belong elsewhere; finished without effect
            is_single = (opcode != `OPC_SOFTWARE_TRAP) && (opcode != `OPC_WAIT);
         end
      endcase
   end

   always_comb
   begin
      if (opcode == `OPC_TEST_ACC)
      begin
         test_value = acc;
      end
      else if (opcode == `OPC_TEST_INDEX)
      begin
         test_value = index_pair[7:0];
      end
      else
      begin
         test_value = mem_operand;
      end
   end

   sign_zero_test #(
      .WIDTH (8)
   ) u_test (
      .value    (test_value),
      .negative (test_neg),
      .zero     (test_zero)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencing

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state       <= st_idle;
         push_idx    <= `PUSH_PCL;
         opcode_held <= 8'h00;
      end
      else
      begin
         case (state)
            st_idle:
            begin
               push_idx <= `PUSH_PCL;
               if (take)
               begin
                  opcode_held <= opcode;
                  if (opcode == `OPC_SOFTWARE_TRAP)
                  begin
                     state <= st_push;
                  end
                  else if (opcode == `OPC_WAIT)
                  begin
                     state <= st_waiting;
                  end
                  else if (is_double)
                  begin
                     state <= st_second;
                  end
               end
            end
            st_push:
            begin
               push_idx <= push_idx + 3'h1;
               if (push_idx == `PUSH_LAST)
               begin
                  state <= st_set_mask;
               end
            end
            st_set_mask: state <= st_vec_high;
            st_vec_high: state <= st_vec_low;
            st_vec_low:  state <= st_idle;
            st_waiting:
            begin
               if (irq_req)
               begin
                  state <= st_idle;
               end
            end
            st_second:   state <= st_idle;
            default:     state <= st_idle;
         endcase
      end
   end

   // one-cycle instructions finish on their taking edge, the rest on their last state
   assign op_done = (take && is_single) || (state == st_vec_low) ||
                    (state == st_second) || ((state == st_waiting) && irq_req);

   // clocking of the core is held off for the whole wait
   assign clk_run = (state != st_waiting);

   ////////////////////////////////////////////////////////////////////////////
   // stack and vector bus

   always_comb
   begin
      mem_addr  = 16'h0000;
      mem_wdata = 8'h00;
      mem_we    = 1'b0;
      mem_re    = 1'b0;
      if (state == st_push)
      begin
         mem_addr = stack_ptr;
         mem_we   = 1'b1;
         if (push_idx == `PUSH_PCL)
         begin
            mem_wdata = prog_counter[7:0];
         end
         else if (push_idx == `PUSH_PCH)
         begin
            mem_wdata = prog_counter[15:8];
         end
         else if (push_idx == `PUSH_X)
         begin
            mem_wdata = index_pair[7:0];
         end
         else if (push_idx == `PUSH_A)
         begin
            mem_wdata = acc;
         end
         else
         begin
            mem_wdata = condition_flags;
         end
      end
      else if (state == st_vec_high)
      begin
         mem_addr = `VEC_TRAP_HIGH;
         mem_re   = 1'b1;
      end
      else if (state == st_vec_low)
      begin
         mem_addr = `VEC_TRAP_LOW;
         mem_re   = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program counter and stack pointer

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prog_counter <= `RST_PC;
      end
      else if (take && (opcode == `OPC_SOFTWARE_TRAP))
      begin
         prog_counter <= prog_counter + 16'h0001;
      end
      else if (state == st_vec_high)
      begin
         prog_counter[15:8] <= mem_rdata;
      end
      else if (state == st_vec_low)
      begin
         prog_counter[7:0] <= mem_rdata;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stack_ptr <= `RST_STACKPTR;
      end
      else if (state == st_push)
      begin
         stack_ptr <= stack_ptr - 16'h0001;
      end
      else if ((state == st_second) && (opcode_held == `OPC_PAIR_TO_STACKPTR))
      begin
         stack_ptr <= index_pair - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // accumulator and index pair

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         acc <= `RST_ACC;
      end
      else if (take && (opcode == `OPC_FLAGS_TO_ACC))
      begin
         acc <= condition_flags;
      end
      else if (take && (opcode == `OPC_INDEX_TO_ACC))
      begin
         acc <= index_pair[7:0];
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         index_pair <= `RST_INDEX;
      end
      else if (take && (opcode == `OPC_ACC_TO_INDEX))
      begin
         index_pair[7:0] <= acc;
      end
      else if ((state == st_second) && (opcode_held == `OPC_STACKPTR_TO_PAIR))
      begin
         index_pair <= stack_ptr + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // condition flags

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         condition_flags <= `RST_FLAGS;
      end
      else if (take && (opcode == `OPC_WAIT))
      begin
         condition_flags[`FLAG_I] <= 1'b0;
      end
      else if (take && is_test)
      begin
         // half-carry, mask and carry kept
         condition_flags[`FLAG_V] <= 1'b0;
         condition_flags[`FLAG_N] <= test_neg;
         condition_flags[`FLAG_Z] <= test_zero;
      end
      else if (state == st_set_mask)
      begin
         condition_flags[`FLAG_I] <= 1'b1;
      end
      else if ((state == st_second) && (opcode_held == `OPC_FLAGS_TO_CCR))
      begin
         condition_flags <= acc;
      end
   end
endmodule

`default_nettype wire

// [tail_exec_asserts.sv]
/*
 port checker for the tail executor;
 assumes a bind onto tail_exec, one clock domain
*/
`timescale 1ns/1ps
`default_nettype none
module tail_exec_asserts (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        op_valid,
   input wire logic [7:0]  opcode,
   input wire logic        irq_req,
   input wire logic        op_ready,
   input wire logic        op_done,
   input wire logic        clk_run,
   input wire logic        mem_we,
   input wire logic [7:0]  acc,
   input wire logic [15:0] index_pair,
   input wire logic [15:0] stack_ptr,
   input wire logic [7:0]  condition_flags
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   logic take;
   assign take = op_valid && op_ready;
   sequence trap_take;
      take && opcode == 8'h83;
   endsequence
   sequence five_pushes;
      mem_we [*5] ##1 !mem_we;
   endsequence
   sequence wait_take;
      take && opcode == 8'h8f;
   endsequence
   chk_trap_len: assert property (trap_take |-> ##8 op_done)
      else $error("trap not done in its ninth cycle");
   chk_trap_push: assert property (trap_take |=> five_pushes)
      else $error("trap push count wrong");
   chk_trap_mask: assert property (trap_take |-> ##9 condition_flags[3])
      else $error("trap left mask clear");
   chk_wait_mask: assert property (wait_take |=> !condition_flags[3]
      && (condition_flags | 8'h08) == ($past(condition_flags) | 8'h08))
      else $error("wait flags wrong");
   chk_wait_stop: assert property (wait_take |=> !clk_run && !op_ready)
      else $error("wait did not stop clocking");
   chk_wait_wake: assert property (!clk_run |-> op_done == irq_req)
      else $error("wake not tied to interrupt");
   chk_test_flags: assert property (take && opcode == 8'h4d |=>
      condition_flags[7:1] == {1'b0, $past(condition_flags[6:3]), $past(acc[7]),
      $past(acc) == 8'h00})
      else $error("test flags wrong");
   chk_pair_load: assert property (take && opcode == 8'h95 |->
      ##2 index_pair == $past(stack_ptr, 2) + 16'h1)
      else $error("pair not stack pointer plus one");
   chk_acc_index: assert property (take && opcode == 8'h97 |=>
      index_pair[7:0] == $past(acc))
      else $error("index low not accumulator");
   chk_single_done: assert property (take && (opcode == 8'h85 || opcode == 8'h97
      || opcode == 8'h9f || opcode == 8'h4d || opcode == 8'h5d || opcode == 8'h3d
      || opcode == 8'h6d || opcode == 8'h7d) |-> op_done)
      else $error("single-cycle op not done at once");
   chk_double_done: assert property (take && (opcode == 8'h84 || opcode == 8'h94
      || opcode == 8'h95) |-> !op_done ##1 (op_done && !op_ready))
      else $error("two-cycle op not done in its second cycle");
   chk_sp_load: assert property (take && opcode == 8'h94 |->
      ##2 stack_ptr == $past(index_pair, 2) - 16'h1)
      else $error("stack pointer not pair minus one");
endmodule
bind tail_exec tail_exec_asserts i_chk (.ref_clk, .sys_rst, .op_valid, .opcode, .irq_req,
   .op_ready, .op_done, .clk_run, .mem_we, .acc, .index_pair, .stack_ptr, .condition_flags);
`default_nettype wire

// [stack_mem.sv]
/*
 memory on the core bus for stack and vector;
 assumes same-cycle reads as the executor expects
*/
`timescale 1ns/1ps
`default_nettype none
module stack_mem (
   input wire logic        ref_clk,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  mem_wdata,
   input wire logic        mem_we,
   input wire logic        mem_re,
   output logic [7:0]      mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] junk = 8'h00;
   always @(posedge ref_clk)
   begin
      junk <= junk + 8'h35;
      if (mem_we)
         mem[mem_addr] <= mem_wdata;
   end
   // unselected reads see a moving pattern, never stale data
   assign mem_rdata = mem_re ? mem[mem_addr] : junk;
endmodule
`default_nettype wire

// [cpu_tail_instruction_exec_tb.sv]
/*
 random and table-driven bench for the tail executor;
 assumes stack_mem as memory and the bound checker
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_tail_instruction_exec_tb;
   logic        ref_clk = 0, sys_rst = 1, op_valid = 0, irq_req = 0;
   logic [7:0]  opcode = 0, mem_operand = 0, mem_rdata, mem_wdata, acc, condition_flags;
   logic        op_ready, op_done, clk_run, mem_we, mem_re;
   logic [15:0] mem_addr, index_pair, stack_ptr, prog_counter, ex, es, ep;
   logic [7:0]  ea, ef;
   logic [7:0]  em [0:65535];
   logic [7:0]  ops [13] = '{8'h83, 8'h8f, 8'h84, 8'h85, 8'h97, 8'h9f, 8'h95, 8'h94,
                            8'h4d, 8'h5d, 8'h3d, 8'h6d, 8'h7d};
   int          lens [13] = '{9, 4, 2, 1, 1, 1, 2, 2, 1, 1, 1, 1, 1};
   int          error_cnt = 0, checked = 0, k;
   logic        hung = 0;
   tail_exec i_tail_exec (.ref_clk, .sys_rst, .op_valid, .opcode, .mem_operand, .irq_req,
      .mem_rdata, .op_ready, .op_done, .clk_run, .mem_addr, .mem_wdata, .mem_we, .mem_re,
      .acc, .index_pair, .stack_ptr, .prog_counter, .condition_flags);
   stack_mem i_stack_mem (.ref_clk, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);
   initial
      forever #2 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, exp, input string what);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic predict(input logic [7:0] op, opnd);
      logic [7:0]  v;
      logic [39:0] p;
      v = op == 8'h4d ? ea : op == 8'h5d ? ex[7:0] : opnd;
      case (op)
         8'h83:
         begin
            ep = ep + 16'h1;
            p = {ef, ea, ex[7:0], ep[15:8], ep[7:0]};
            for (int i = 0; i < 5; i++)
               em[es - 16'(i)] = p[8*i +: 8];
            es = es - 16'h5;
            ef[3] = 1'b1;
            ep = {em[16'hfffc], em[16'hfffd]};
         end
         8'h8f: ef[3] = 1'b0;
         8'h84: ef = ea;
         8'h85: ea = ef;
         8'h97: ex[7:0] = ea;
         8'h9f: ea = ex[7:0];
         8'h95: ex = es + 16'h1;
         8'h94: es = ex - 16'h1;
         8'h4d, 8'h5d, 8'h3d, 8'h6d, 8'h7d: ef = {1'b0, ef[6:3], v[7], v == 8'h00, ef[0]};
         // codes outside this group finish with no effect
         default: ef = ef;
      endcase
   endtask
   task automatic run(input logic [7:0] op, input int n);
      int          c;
      logic [15:0] s0;
      if (hung)
         return;
      // random idle gaps, otherwise ops follow back to back
      if ($urandom % 4 == 0)
      begin
         op_valid = 0;
         @(negedge ref_clk);
      end
      s0 = es;
      opcode = op;
      mem_operand = 8'($urandom);
      op_valid = 1;
      predict(op, mem_operand);
      @(posedge ref_clk);
      @(negedge ref_clk);
      // a finished single op stays valid so the next call only swaps the code
      if (op_ready !== 1'b1)
         op_valid = 0;
      c = 1;
      while (op_ready !== 1'b1 && c < 50)
      begin
         irq_req = c == 3;
         @(negedge ref_clk);
         c++;
      end
      irq_req = 0;
      if (c == 50)
      begin
         error_cnt++;
         hung = 1;
         $display("[FAIL] %0t op %h never finished", $time, op);
         return;
      end
      chk(16'(c), 16'(n), "cycles");
      chk(acc, ea, "acc");
      chk(index_pair, ex, "pair");
      chk(stack_ptr, es, "sp");
      chk(prog_counter, ep, "pc");
      chk(condition_flags, ef, "flags");
      if (op == 8'h83)
         for (int i = 0; i < 5; i++)
            chk(i_stack_mem.mem[s0 - 16'(i)], em[s0 - 16'(i)], "push");
      $display("test %h done", op);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'hfafd95cd));
      ea = 8'h00;
      ef = 8'h68;
      ex = 16'h0000;
      es = 16'h00ff;
      ep = 16'h0000;
      em[16'hfffc] = 8'($urandom);
      em[16'hfffd] = 8'($urandom);
      i_stack_mem.mem[16'hfffc] = em[16'hfffc];
      i_stack_mem.mem[16'hfffd] = em[16'hfffd];
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      sys_rst = 0;
      chk(condition_flags, 8'h68, "reset flags");
      // every listed code once, one unlisted code, then two traps back to back, then 300 random codes
      for (int i = 0; i < 13; i++)
         run(ops[i], lens[i]);
      run(8'h9d, 1);
      run(8'h83, 9);
      run(8'h83, 9);
      for (int i = 0; i < 300; i++)
      begin
         k = $urandom % 13;
         run(ops[k], lens[k]);
      end
      finish_test();
   end
endmodule
`default_nettype wire
